/* dv/cscp_chk.sv */
// Purpose: Concurrent checks on the stack, context and pointer block ports
// Assumes: Single clock, synchronous active-high reset
// Notes: Bound to every cscp_core instance
`timescale 1ns/1ps
`default_nettype none
module cscp_chk
    import cscp_pkg::*;
#(
    parameter int unsigned STACK_DEPTH = STK_DEPTH
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_push,
    input wire logic i_pop,
    input wire logic i_stack_reset_en,
    input wire logic i_irq_return,
    input wire logic [5:0] i_op_index,
    input wire logic [7:0] i_data_rdata,
    input wire logic [STK_CNT_W-1:0] o_stack_level,
    input wire logic [RET_ADDR_W-1:0] o_ret_addr,
    input wire logic o_ret_valid,
    input wire logic o_stack_overflow_flag,
    input wire logic o_stack_underflow_flag,
    input wire logic o_soft_reset,
    input wire logic o_restore,
    input wire logic o_op_illegal,
    input wire logic o_busy,
    input wire logic o_prog_rd,
    input wire logic o_data_rd,
    input wire logic [7:0] o_rdata,
    input wire logic o_rdata_valid
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);
    wire psh = i_push && !i_pop;
    wire pp = i_pop && !i_push;
    wire full = o_stack_level == STK_CNT_W'(STACK_DEPTH);
    wire serr = (psh && full) || (pp && o_stack_level == 5'h00);
    ////////////////////////////////////////////////////////////////////////////////
    chk_push_level: assert property (
        psh && !full |=> o_stack_level == $past(o_stack_level) + 5'h01)
        else $error("push did not raise the stack level");
    chk_ovf_flag: assert property (
        psh && full |=> o_stack_overflow_flag)
        else $error("push on full stack did not set overflow");
    chk_unf_flag: assert property (
        pp && o_stack_level == 5'h00 |=> o_stack_underflow_flag && o_ret_valid
        && o_ret_addr == 15'h0000) else $error("pop on empty stack mishandled");
    chk_soft_reset: assert property (
        !$past(i_srst) |-> o_soft_reset == $past(serr && i_stack_reset_en))
        else $error("soft reset pulse does not follow a stack error");
    chk_ctx_restore: assert property (
        !$past(i_srst) |-> o_restore == $past(i_irq_return))
        else $error("restore pulse does not follow interrupt return");
    chk_prog_extra: assert property (
        o_prog_rd |-> o_busy ##1 (o_busy && !o_prog_rd) ##1 o_rdata_valid)
        else $error("program read did not take the extra cycle");
    chk_data_read: assert property (
        o_data_rd |=> o_rdata_valid && o_rdata == $past(i_data_rdata))
        else $error("data read result wrong");
    chk_op_legal: assert property (
        !$past(i_srst) |-> o_op_illegal == ($past(i_op_index) >= NUM_INSTR))
        else $error("illegal operation flag wrong");
endmodule
bind cscp_core cscp_chk #(.STACK_DEPTH(STACK_DEPTH)) cscp_chk_i (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_push(i_push), .i_pop(i_pop),
    .i_stack_reset_en(i_stack_reset_en), .i_irq_return(i_irq_return),
    .i_op_index(i_op_index), .i_data_rdata(i_data_rdata), .o_stack_level(o_stack_level),
    .o_ret_addr(o_ret_addr), .o_ret_valid(o_ret_valid),
    .o_stack_overflow_flag(o_stack_overflow_flag), .o_soft_reset(o_soft_reset),
    .o_stack_underflow_flag(o_stack_underflow_flag), .o_restore(o_restore),
    .o_op_illegal(o_op_illegal), .o_busy(o_busy), .o_prog_rd(o_prog_rd),
    .o_data_rd(o_data_rd), .o_rdata(o_rdata), .o_rdata_valid(o_rdata_valid)
);
`default_nettype wire

/* dv/testbench.sv */
// Purpose: Directed bench for the stack, context and pointer block
// Assumes: Inputs change on falling edges, outputs are read there too
// Notes: Full stack depth of 16 is kept, the run is short anyway
`timescale 1ns/1ps
`default_nettype none
module testbench
    import cscp_pkg::*;
();
    logic clk = 1'b0, srst = 1'b1, push = 1'b0, pop = 1'b0, rst_en = 1'b0;
    logic clr_o = 1'b0, clr_u = 1'b0, ient = 1'b0, iret = 1'b0, pwr = 1'b0, psel = 1'b0;
    logic phi = 1'b0, req = 1'b0, awr = 1'b0, asel = 1'b0;
    logic [14:0] push_a = 15'h0000;
    logic [7:0] lw = 8'h00, pwd = 8'h00, awd = 8'h00, drd = 8'h00;
    logic [4:0] lst = 5'h00, lbsr = 5'h00;
    logic [5:0] opi = 6'h00, ofs = 6'h00;
    logic [6:0] dir = 7'h00, lpc = 7'h00;
    logic [6:0] rpc;
    logic [4:0] rbsr;
    logic [15:0] p1;
    logic retv;
    logic [1:0] mode = 2'b00;
    logic [13:0] prd = 14'h0000;
    logic [14:0] ret, pad;
    logic [4:0] lvl, rst_st;
    logic [7:0] rw, dwd, rdat;
    logic [15:0] p0;
    logic [11:0] dad;
    logic ovf, unf, srt, rest, ill, busy, drdo, dwr, prdo, rv;
    int n_mismatch = 0;
    int n_compared = 0;
    cscp_core cscp_core_i (
        .i_ref_clk(clk), .i_srst(srst), .i_push(push), .i_pop(pop), .i_push_addr(push_a),
        .i_stack_reset_en(rst_en), .i_clr_ovf(clr_o), .i_clr_unf(clr_u), .i_irq_entry(ient),
        .i_irq_return(iret), .i_live_w(lw), .i_live_status(lst), .i_live_bsr(lbsr),
        .i_live_pclath(lpc), .i_ptr_wr(pwr), .i_ptr_sel(psel), .i_ptr_hi(phi),
        .i_ptr_wdata(pwd), .i_op_index(opi), .i_acc_req(req), .i_acc_wr(awr),
        .i_acc_mode(mode), .i_acc_ptr_sel(asel), .i_acc_ofs(ofs), .i_dir_addr(dir),
        .i_acc_wdata(awd), .i_data_rdata(drd), .i_prog_rdata(prd), .o_ret_addr(ret),
        .o_ret_valid(retv), .o_stack_level(lvl), .o_stack_overflow_flag(ovf),
        .o_stack_underflow_flag(unf), .o_soft_reset(srt), .o_restore(rest), .o_rest_w(rw),
        .o_rest_status(rst_st), .o_rest_bsr(rbsr), .o_rest_pclath(rpc), .o_ptr0(p0),
        .o_ptr1(p1),
        .o_op_illegal(ill), .o_busy(busy), .o_data_addr(dad), .o_data_rd(drdo),
        .o_data_wr(dwr), .o_data_wdata(dwd), .o_prog_addr(pad), .o_prog_rd(prdo),
        .o_rdata(rdat), .o_rdata_valid(rv)
    );
    initial begin
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc();
        @(negedge clk);
    endtask
    // Each driver holds its strobe for exactly one rising edge
    task automatic stk(input logic pu, input logic po, input logic [14:0] a);
        push = pu;
        pop = po;
        push_a = a;
        cyc();
        push = 1'b0;
        pop = 1'b0;
    endtask
    task automatic pw(input logic s, input logic h, input logic [7:0] d);
        pwr = 1'b1;
        psel = s;
        phi = h;
        pwd = d;
        cyc();
        pwr = 1'b0;
    endtask
    task automatic acc(input logic w, input logic [1:0] m, input logic s, input logic [5:0] o);
        req = 1'b1;
        awr = w;
        mode = m;
        asel = s;
        ofs = o;
        cyc();
        req = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_stack();
        for (int i = 0; i < 16; i++) begin
            stk(1'b1, 1'b0, 15'h4000 + 15'(i));
            chk("lvl", 16'(lvl), 16'(i + 1));
        end
        stk(1'b1, 1'b0, 15'h7fff);
        chk("ovf", 16'(ovf), 16'h0001);
        chk("lvl_full", 16'(lvl), 16'h0010);
        for (int i = 15; i >= 0; i--) begin
            stk(1'b0, 1'b1, 15'h0000);
            chk("ret", 16'(ret), 16'h4000 + 16'(i));
            chk("ret_v", 16'(retv), 16'h0001);
        end
        stk(1'b0, 1'b1, 15'h0000);
        chk("unf", 16'(unf), 16'h0001);
        chk("ret_empty", 16'(ret), 16'h0000);
        chk("no_srst", 16'(srt), 16'h0000);
        rst_en = 1'b1;
        stk(1'b0, 1'b1, 15'h0000);
        chk("srst", 16'(srt), 16'h0001);
        rst_en = 1'b0;
        clr_o = 1'b1;
        clr_u = 1'b1;
        cyc();
        clr_o = 1'b0;
        clr_u = 1'b0;
        chk("ovf_clr", 16'({ovf, unf}), 16'h0000);
    endtask
    task automatic t_ctx();
        pw(1'b0, 1'b1, 8'h12);
        pw(1'b0, 1'b0, 8'h34);
        chk("p0", p0, 16'h1234);
        lw = 8'ha5;
        lst = 5'h15;
        lbsr = 5'h0a;
        lpc = 7'h5b;
        ient = 1'b1;
        cyc();
        ient = 1'b0;
        pw(1'b0, 1'b0, 8'h99);
        iret = 1'b1;
        cyc();
        iret = 1'b0;
        chk("restore", 16'(rest), 16'h0001);
        chk("p0_back", p0, 16'h1234);
        chk("shadow", {rw, 3'h0, rst_st}, 16'ha515);
        chk("shadow2", {1'b0, rpc, 3'h0, rbsr}, 16'h5b0a);
    endtask
    task automatic t_acc();
        // Bit 7 of the high byte selects program memory
        pw(1'b0, 1'b1, 8'h80);
        pw(1'b0, 1'b0, 8'h05);
        prd = 14'h3a5c;
        acc(1'b0, 2'b01, 1'b0, 6'h00);
        chk("prog_rd", {prdo, busy, pad[13:0]}, 16'hc005);
        cyc();
        chk("busy2", 16'(busy), 16'h0001);
        cyc();
        chk("prog_dat", {7'h00, rv, rdat}, 16'h015c);
        acc(1'b1, 2'b01, 1'b0, 6'h00);
        chk("prog_wr", {prdo, dwr, busy}, 16'h0001);
        cyc();
        // Linear 0x2051 is offset 81: bank 1, byte 0x21
        pw(1'b1, 1'b1, 8'h20);
        chk("wr_no_rv", 16'(rv), 16'h0000);
        pw(1'b1, 1'b0, 8'h51);
        chk("p1", p1, 16'h2051);
        drd = 8'h77;
        acc(1'b0, 2'b01, 1'b1, 6'h00);
        chk("lin_rd", {3'h0, drdo, dad}, 16'h10a1);
        cyc();
        chk("lin_dat", {busy, 6'h00, rv, rdat}, 16'h0177);
        awd = 8'h3c;
        acc(1'b1, 2'b10, 1'b1, 6'h3f);
        chk("rel_wr", {3'h0, dwr, dad}, 16'h10a0);
        chk("rel_dat", 16'(dwd), 16'h003c);
        cyc();
        lbsr = 5'h03;
        dir = 7'h25;
        acc(1'b0, 2'b00, 1'b0, 6'h00);
        chk("dir_rd", {3'h0, drdo, dad}, 16'h11a5);
        cyc();
    endtask
    task automatic t_op();
        opi = 6'h30;
        cyc();
        chk("op48", 16'(ill), 16'h0000);
        opi = 6'h31;
        cyc();
        chk("op49", 16'(ill), 16'h0001);
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) cyc();
        srst = 1'b0;
        cyc();
        t_stack();
        t_ctx();
        t_acc();
        t_op();
        wrap_up();
    end
    // The tests need well under 200 cycles
    initial begin
        #100000;
        n_mismatch++;
        wrap_up();
    end
endmodule
`default_nettype wire

/* include/cscp_pkg.sv */
// Purpose: Shared constants for the stack, context and pointer block
// Assumes: One instruction clock, synchronous active-high reset
// Notes: Data addresses are 12 bits: 5-bit bank, 7-bit offset
package cscp_pkg;
    // Return-address stack
    localparam int unsigned STK_DEPTH = 16;
    localparam int unsigned STK_CNT_W = 5;
    localparam int unsigned RET_ADDR_W = 15;
    // Pointers and memories
    localparam int unsigned PTR_W = 16;
    localparam int unsigned DATA_ADDR_W = 12;
    localparam int unsigned PROG_WORD_W = 14;
    localparam int unsigned PROG_SEL_BIT = 7;
    localparam logic [15:0] LIN_BASE = 16'h2000;
    localparam logic [15:0] LIN_LAST = 16'h29ff;
    localparam logic [11:0] GPR_PER_BANK = 12'h050;
    localparam logic [6:0] GPR_BANK_OFS = 7'h20;
    // Instruction set
    localparam logic [5:0] NUM_INSTR = 6'h31;
    // Reset values
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // Operand addressing modes
    typedef enum logic [1:0] {
        CSCP_AM_DIRECT = 2'b00,
        CSCP_AM_INDIRECT = 2'b01,
        CSCP_AM_RELATIVE = 2'b10
    } cscp_amode_e;
    // Access sequencer
    typedef enum logic [1:0] {
        CSCP_ST_IDLE = 2'b00,
        CSCP_ST_DATA = 2'b01,
        CSCP_ST_PROG = 2'b10,
        CSCP_ST_PWAIT = 2'b11
    } cscp_state_e;
endpackage

/* rtl/cscp_core.sv */
// Purpose: Return stack, interrupt shadows and file select pointers of a small CPU
// Assumes: All inputs come from core logic on i_ref_clk
// Notes: Notes on behaviour listed below
`timescale 1ns/1ps
`default_nettype none
module cscp_core
    import cscp_pkg::*;
#(
    parameter int unsigned STACK_DEPTH = STK_DEPTH
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_push,
    input wire logic i_pop,
    input wire logic [RET_ADDR_W-1:0] i_push_addr,
    input wire logic i_stack_reset_en,
    input wire logic i_clr_ovf,
    input wire logic i_clr_unf,
    input wire logic i_irq_entry,
    input wire logic i_irq_return,
    input wire logic [7:0] i_live_w,
    input wire logic [4:0] i_live_status,
    input wire logic [4:0] i_live_bsr,
    input wire logic [6:0] i_live_pclath,
    input wire logic i_ptr_wr,
    input wire logic i_ptr_sel,
    input wire logic i_ptr_hi,
    input wire logic [7:0] i_ptr_wdata,
    input wire logic [5:0] i_op_index,
    input wire logic i_acc_req,
    input wire logic i_acc_wr,
    input wire logic [1:0] i_acc_mode,
    input wire logic i_acc_ptr_sel,
    input wire logic [5:0] i_acc_ofs,
    input wire logic [6:0] i_dir_addr,
    input wire logic [7:0] i_acc_wdata,
    input wire logic [7:0] i_data_rdata,
    input wire logic [PROG_WORD_W-1:0] i_prog_rdata,
    output logic [RET_ADDR_W-1:0] o_ret_addr,
    output logic o_ret_valid,
    output logic [STK_CNT_W-1:0] o_stack_level,
    output logic o_stack_overflow_flag,
    output logic o_stack_underflow_flag,
    output logic o_soft_reset,
    output logic o_restore,
    output logic [7:0] o_rest_w,
    output logic [4:0] o_rest_status,
    output logic [4:0] o_rest_bsr,
    output logic [6:0] o_rest_pclath,
    output logic [PTR_W-1:0] o_ptr0,
    output logic [PTR_W-1:0] o_ptr1,
    output logic o_op_illegal,
    output logic o_busy,
    output logic [DATA_ADDR_W-1:0] o_data_addr,
    output logic o_data_rd,
    output logic o_data_wr,
    output logic [7:0] o_data_wdata,
    output logic [RET_ADDR_W-1:0] o_prog_addr,
    output logic o_prog_rd,
    output logic [7:0] o_rdata,
    output logic o_rdata_valid
);
    if (STACK_DEPTH < 2 || STACK_DEPTH > STK_DEPTH) begin : g_bad_depth
        $error("STACK_DEPTH must lie between 2 and 16");
    end

    localparam logic [STK_CNT_W-1:0] DEPTH_CNT = STK_CNT_W'(STACK_DEPTH);

    ////////////////////////////////////////////////////////////////////////
    // Return-address stack
    logic [RET_ADDR_W-1:0] stack_mem [STACK_DEPTH];
    logic [STK_CNT_W-1:0] level_q;
    logic [RET_ADDR_W-1:0] ret_addr_q;
    logic ret_valid_q, ovf_q, unf_q, soft_rst_q;

    wire stack_full = (level_q == DEPTH_CNT);
    wire stack_empty = (level_q == '0);
    wire push_ok = i_push && !i_pop && !stack_full;
    wire pop_ok = i_pop && !i_push && !stack_empty;
    wire ovf_evt = i_push && !i_pop && stack_full;
    wire unf_evt = i_pop && !i_push && stack_empty;
    wire err_reset = i_stack_reset_en && (ovf_evt || unf_evt);
    wire [STK_CNT_W-1:0] top_idx = level_q - 1'b1;

    always_ff @(posedge i_ref_clk) begin
        if (push_ok) begin
            stack_mem[level_q[3:0]] <= i_push_addr;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst || err_reset) begin
            level_q <= '0;
        end else if (push_ok) begin
            level_q <= level_q + 1'b1;
        end else if (pop_ok) begin
            level_q <= top_idx;
        end
    end

    // Underflow returns address zero, like an empty stack slot
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ret_addr_q <= '0;
            ret_valid_q <= 1'b0;
        end else begin
            ret_valid_q <= i_pop && !i_push;
            if (pop_ok) begin
                ret_addr_q <= stack_mem[top_idx[3:0]];
            end else if (unf_evt) begin
                ret_addr_q <= '0;
            end
        end
    end

    // Flags survive the error reset so software can see the cause; set beats clear
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ovf_q <= 1'b0;
            unf_q <= 1'b0;
            soft_rst_q <= 1'b0;
        end else begin
            ovf_q <= ovf_evt || (ovf_q && !i_clr_ovf);
            unf_q <= unf_evt || (unf_q && !i_clr_unf);
            soft_rst_q <= err_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pointers and interrupt shadows
    logic [PTR_W-1:0] ptr0_q, ptr1_q, sh_ptr0_q, sh_ptr1_q;
    logic [7:0] sh_w_q;
    logic [4:0] sh_status_q, sh_bsr_q;
    logic [6:0] sh_pclath_q;
    logic restore_q;

    wire [PTR_W-1:0] ptr_wr_val0 = i_ptr_hi ? {i_ptr_wdata, ptr0_q[7:0]}
                                            : {ptr0_q[15:8], i_ptr_wdata};
    wire [PTR_W-1:0] ptr_wr_val1 = i_ptr_hi ? {i_ptr_wdata, ptr1_q[7:0]}
                                            : {ptr1_q[15:8], i_ptr_wdata};

    // Restore wins over a same-cycle pointer write
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ptr0_q <= PTR_RST;
            ptr1_q <= PTR_RST;
        end else if (i_irq_return) begin
            ptr0_q <= sh_ptr0_q;
            ptr1_q <= sh_ptr1_q;
        end else if (i_ptr_wr) begin
            if (i_ptr_sel) begin
                ptr1_q <= ptr_wr_val1;
            end else begin
                ptr0_q <= ptr_wr_val0;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            sh_ptr0_q <= PTR_RST;
            sh_ptr1_q <= PTR_RST;
            sh_w_q <= BYTE_RST;
            sh_status_q <= '0;
            sh_bsr_q <= '0;
            sh_pclath_q <= '0;
        end else if (i_irq_entry) begin
            sh_ptr0_q <= ptr0_q;
            sh_ptr1_q <= ptr1_q;
            sh_w_q <= i_live_w;
            sh_status_q <= i_live_status;
            sh_bsr_q <= i_live_bsr;
            sh_pclath_q <= i_live_pclath;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            restore_q <= 1'b0;
        end else begin
            restore_q <= i_irq_return;
        end
    end

    logic op_illegal_q;
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            op_illegal_q <= 1'b0;
        end else begin
            op_illegal_q <= (i_op_index >= NUM_INSTR);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operand address generation
    wire [PTR_W-1:0] acc_ptr = i_acc_ptr_sel ? ptr1_q : ptr0_q;
    wire [PTR_W-1:0] rel_addr = acc_ptr + {{10{i_acc_ofs[5]}}, i_acc_ofs};
    wire [PTR_W-1:0] dir_addr = {4'h0, i_live_bsr, i_dir_addr};
    logic [PTR_W-1:0] eff_addr;
    always_comb begin
        unique case (i_acc_mode)
            CSCP_AM_INDIRECT: eff_addr = acc_ptr;
            CSCP_AM_RELATIVE: eff_addr = rel_addr;
            default: eff_addr = dir_addr;
        endcase
    end

    wire is_prog = eff_addr[8 + PROG_SEL_BIT];
    wire is_trad = (eff_addr[15:12] == 4'h0);
    wire is_lin = (eff_addr >= LIN_BASE) && (eff_addr <= LIN_LAST);
    wire [11:0] lin_ofs = eff_addr[11:0];
    wire [11:0] lin_quot = lin_ofs / GPR_PER_BANK;
    wire [11:0] lin_rem = lin_ofs % GPR_PER_BANK;
    wire [DATA_ADDR_W-1:0] lin_addr = {lin_quot[4:0], lin_rem[6:0] + GPR_BANK_OFS};
    wire [DATA_ADDR_W-1:0] data_addr = is_lin ? lin_addr : eff_addr[11:0];
    wire data_hit = !is_prog && (is_trad || is_lin);

    ////////////////////////////////////////////////////////////////////////
    // Access sequencer
    cscp_state_e st_q;
    logic busy_q, data_rd_q, data_wr_q, prog_rd_q, rdv_q;
    logic [DATA_ADDR_W-1:0] data_addr_q;
    logic [7:0] wdata_q, rdata_q;
    logic [RET_ADDR_W-1:0] prog_addr_q;
    logic zero_read_q;

    wire take = i_acc_req && (st_q == CSCP_ST_IDLE);

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            st_q <= CSCP_ST_IDLE;
        end else begin
            unique case (st_q)
                CSCP_ST_IDLE: begin
                    if (take) begin
                        st_q <= is_prog ? CSCP_ST_PROG : CSCP_ST_DATA;
                    end
                end
                CSCP_ST_PROG: st_q <= CSCP_ST_PWAIT;
                CSCP_ST_DATA, CSCP_ST_PWAIT: st_q <= CSCP_ST_IDLE;
            endcase
        end
    end

    // Unmapped data addresses read zero and raise no strobe
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            busy_q <= 1'b0;
            data_rd_q <= 1'b0;
            data_wr_q <= 1'b0;
            prog_rd_q <= 1'b0;
            data_addr_q <= '0;
            wdata_q <= BYTE_RST;
            prog_addr_q <= '0;
            zero_read_q <= 1'b0;
        end else begin
            busy_q <= take || (st_q == CSCP_ST_PROG);
            data_rd_q <= take && !i_acc_wr && data_hit;
            data_wr_q <= take && i_acc_wr && data_hit;
            prog_rd_q <= take && !i_acc_wr && is_prog;
            if (take) begin
                data_addr_q <= data_addr;
                wdata_q <= i_acc_wdata;
                prog_addr_q <= eff_addr[RET_ADDR_W-1:0];
                zero_read_q <= !is_prog && !data_hit && !i_acc_wr;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            rdata_q <= BYTE_RST;
            rdv_q <= 1'b0;
        end else begin
            // Program writes still take the extra cycle but return nothing
            rdv_q <= (st_q == CSCP_ST_PWAIT && !prog_wr_q)
                || (st_q == CSCP_ST_DATA && (data_rd_q || zero_read_q));
            if (st_q == CSCP_ST_DATA && (data_rd_q || zero_read_q)) begin
                rdata_q <= zero_read_q ? BYTE_RST : i_data_rdata;
            end else if (st_q == CSCP_ST_PWAIT && !prog_wr_q) begin
                rdata_q <= i_prog_rdata[7:0];
            end
        end
    end

    logic prog_wr_q;
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            prog_wr_q <= 1'b0;
        end else if (take) begin
            prog_wr_q <= i_acc_wr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_ret_addr = ret_addr_q;
    assign o_ret_valid = ret_valid_q;
    assign o_stack_level = level_q;
    assign o_stack_overflow_flag = ovf_q;
    assign o_stack_underflow_flag = unf_q;
    assign o_soft_reset = soft_rst_q;
    assign o_restore = restore_q;
    assign o_rest_w = sh_w_q;
    assign o_rest_status = sh_status_q;
    assign o_rest_bsr = sh_bsr_q;
    assign o_rest_pclath = sh_pclath_q;
    assign o_ptr0 = ptr0_q;
    assign o_ptr1 = ptr1_q;
    assign o_op_illegal = op_illegal_q;
    assign o_busy = busy_q;
    assign o_data_addr = data_addr_q;
    assign o_data_rd = data_rd_q;
    assign o_data_wr = data_wr_q;
    assign o_data_wdata = wdata_q;
    assign o_prog_addr = prog_addr_q;
    assign o_prog_rd = prog_rd_q;
    assign o_rdata = rdata_q;
    assign o_rdata_valid = rdv_q;
endmodule
`default_nettype wire
